/* core/ftg_gate_defines.vh */
// Constants for the four-state gate library: value codes and function selects.
// Assumes each logic value travels as a two-bit code on plain wires.
`ifndef FTG_GATE_DEFINES_VH
`define FTG_GATE_DEFINES_VH

// ****************************************
// Four-state value codes
// ****************************************
`define FTG_V0 2'h0
`define FTG_V1 2'h1
`define FTG_VX 2'h2
`define FTG_VZ 2'h3

// ****************************************
// Simple gate and array function selects
// ****************************************
`define FTG_OP_BUF 3'h0
`define FTG_OP_INV 3'h1
`define FTG_OP_AND 3'h2
`define FTG_OP_NAND 3'h3
`define FTG_OP_OR 3'h4
`define FTG_OP_NOR 3'h5
`define FTG_OP_XOR 3'h6
`define FTG_OP_XNOR 3'h7

// ****************************************
// Compound gate function selects
// ****************************************
`define FTG_CMP_AND_OR 2'h0
`define FTG_CMP_OR_AND 2'h1
`define FTG_CMP_AND_NOR 2'h2
`define FTG_CMP_OR_NAND 2'h3

// ****************************************
// Synchronised control word layout
// ****************************************
`define FTG_CTL_W 8
`define FTG_CTL_RST 8'h00
`define FTG_CTL_OP_LSB 5
`define FTG_CTL_MODE_BIT 4
`define FTG_CTL_EN_LSB 2
`define FTG_CTL_CMP_LSB 0

`endif

/* core/ftg_gate_lib.v */
// Four-state gate array and compound gate with registered outputs.
// Assumes inputs arrive asynchronously and are two-bit value codes.
`timescale 1ns/1ps
`default_nettype none
`include "ftg_gate_defines.vh"

module ftg_gate_lib #(
  parameter N_IN = 2,
  parameter N_GATE = 3
) (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Gate array inputs and controls
  input wire [2*N_IN*N_GATE-1:0] gate_in,
  input wire [2:0] gate_op,
  input wire tri_mode,
  input wire [1:0] tri_en,
  // Compound gate control
  input wire [1:0] cmp_op,
  // Gate array outputs
  output reg [2*N_GATE-1:0] gate_val_r,
  output reg [N_GATE-1:0] gate_oe_r,
  // Compound gate output
  output reg [1:0] cmp_val_r
);

  // ****************************************
  // Resolution of one gate from input flags
  // ****************************************
  function [1:0] ftg_resolve;
    input [2:0] op;
    input f0;
    input f1;
    input any0;
    input any1;
    input all0;
    input all1;
    input anyu;
    input par;
    reg [1:0] r;
    begin
      r = `FTG_VX;
      case (op)
        `FTG_OP_BUF: r = f0 ? `FTG_V0 : (f1 ? `FTG_V1 : `FTG_VX);
        `FTG_OP_INV: r = f0 ? `FTG_V1 : (f1 ? `FTG_V0 : `FTG_VX);
        `FTG_OP_AND: r = any0 ? `FTG_V0 : (all1 ? `FTG_V1 : `FTG_VX);
        `FTG_OP_NAND: r = any0 ? `FTG_V1 : (all1 ? `FTG_V0 : `FTG_VX);
        `FTG_OP_OR: r = any1 ? `FTG_V1 : (all0 ? `FTG_V0 : `FTG_VX);
        `FTG_OP_NOR: r = any1 ? `FTG_V0 : (all0 ? `FTG_V1 : `FTG_VX);
        `FTG_OP_XOR: r = anyu ? `FTG_VX : {1'b0, par};
        `FTG_OP_XNOR: r = anyu ? `FTG_VX : {1'b0, ~par};
        default: r = `FTG_VX;
      endcase
      ftg_resolve = r;
    end
  endfunction

  // ****************************************
  // Single-value decode
  // ****************************************
  function ftg_is_zero;
    input [1:0] v;
    begin
      ftg_is_zero = (v == `FTG_V0);
    end
  endfunction

  function ftg_is_one;
    input [1:0] v;
    begin
      ftg_is_one = (v == `FTG_V1);
    end
  endfunction

  // ****************************************
  // Reset synchroniser
  // ****************************************
  reg rst_s1_r;
  reg rst_s2_r;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end

  // ****************************************
  // Input synchronisers
  // ****************************************
  reg [2*N_IN*N_GATE-1:0] in_s1_r;
  reg [2*N_IN*N_GATE-1:0] in_s2_r;
  reg [`FTG_CTL_W-1:0] ctl_s1_r;
  reg [`FTG_CTL_W-1:0] ctl_s2_r;
  always @(posedge clk or negedge rst_s2_r) begin
    if (!rst_s2_r) begin
      in_s1_r <= {2*N_IN*N_GATE{1'b0}};
      in_s2_r <= {2*N_IN*N_GATE{1'b0}};
      ctl_s1_r <= `FTG_CTL_RST;
      ctl_s2_r <= `FTG_CTL_RST;
    end else begin
      in_s1_r <= gate_in;
      in_s2_r <= in_s1_r;
      ctl_s1_r <= {gate_op, tri_mode, tri_en, cmp_op};
      ctl_s2_r <= ctl_s1_r;
    end
  end

  wire [2:0] op_s = ctl_s2_r[`FTG_CTL_OP_LSB +: 3];
  wire mode_s = ctl_s2_r[`FTG_CTL_MODE_BIT];
  wire [1:0] en_s = ctl_s2_r[`FTG_CTL_EN_LSB +: 2];
  wire [1:0] cop_s = ctl_s2_r[`FTG_CTL_CMP_LSB +: 2];

  // ****************************************
  // Shared tri-state enable decode
  // ****************************************
  wire en_off = ftg_is_zero(en_s);
  wire en_on = ftg_is_one(en_s);

  // ****************************************
  // Per-input decode; X and Z both unknown
  // ****************************************
  wire [N_IN*N_GATE-1:0] is0;
  wire [N_IN*N_GATE-1:0] is1;
  genvar gi;
  generate
    for (gi = 0; gi < N_IN*N_GATE; gi = gi + 1) begin : g_dec
      assign is0[gi] = ftg_is_zero(in_s2_r[2*gi+1:2*gi]);
      assign is1[gi] = ftg_is_one(in_s2_r[2*gi+1:2*gi]);
    end
  endgenerate

  // ****************************************
  // Gate array and first compound level
  // ****************************************
  wire [2*N_GATE-1:0] arr_val;
  wire [N_GATE-1:0] l1_is0;
  wire [N_GATE-1:0] l1_is1;
  genvar gg;
  generate
    for (gg = 0; gg < N_GATE; gg = gg + 1) begin : g_gate
      wire [N_IN-1:0] z0 = is0[gg*N_IN +: N_IN];
      wire [N_IN-1:0] o1 = is1[gg*N_IN +: N_IN];
      wire a0 = |z0;
      wire a1 = |o1;
      wire l0 = &z0;
      wire l1 = &o1;
      wire au = ~&(z0 | o1);
      wire [1:0] l1v;
      // Forced-0 / forced-1 agreement per gate
      assign arr_val[2*gg+1:2*gg] = ftg_resolve(op_s, z0[0], o1[0], a0, a1, l0, l1, au, ^o1);
      assign l1v = ftg_resolve((cop_s[0] ? `FTG_OP_OR : `FTG_OP_AND), z0[0], o1[0],
                               a0, a1, l0, l1, au, ^o1);
      assign l1_is0[gg] = ftg_is_zero(l1v);
      assign l1_is1[gg] = ftg_is_one(l1v);
    end
  endgenerate

  // ****************************************
  // Second compound level
  // ****************************************
  reg [2:0] op2;
  always @* begin
    case (cop_s)
      `FTG_CMP_AND_OR: op2 = `FTG_OP_OR;
      `FTG_CMP_OR_AND: op2 = `FTG_OP_AND;
      `FTG_CMP_AND_NOR: op2 = `FTG_OP_NOR;
      `FTG_CMP_OR_NAND: op2 = `FTG_OP_NAND;
      default: op2 = `FTG_OP_OR;
    endcase
  end
  wire l2_any0 = |l1_is0;
  wire l2_any1 = |l1_is1;
  wire l2_all0 = &l1_is0;
  wire l2_all1 = &l1_is1;
  wire l2_anyu = ~&(l1_is0 | l1_is1);
  wire [1:0] cmp_val = ftg_resolve(op2, l1_is0[0], l1_is1[0], l2_any0, l2_any1,
                                   l2_all0, l2_all1, l2_anyu, ^l1_is1);

  // ****************************************
  // Output drive and tri-state enable
  // ****************************************
  reg [2*N_GATE-1:0] val_nxt;
  reg [N_GATE-1:0] oe_nxt;
  integer k;
  always @* begin
    val_nxt = arr_val;
    oe_nxt = {N_GATE{1'b1}};
    if (mode_s) begin
      for (k = 0; k < N_GATE; k = k + 1) begin
        if (en_off) begin
          val_nxt[2*k +: 2] = `FTG_VZ;
          oe_nxt[k] = 1'b0;
        end else if (!en_on) begin
          val_nxt[2*k +: 2] = `FTG_VX;
        end
      end
    end
  end

  always @(posedge clk or negedge rst_s2_r) begin
    if (!rst_s2_r) begin
      gate_val_r <= {2*N_GATE{1'b0}};
      gate_oe_r <= {N_GATE{1'b0}};
      cmp_val_r <= `FTG_V0;
    end else begin
      gate_val_r <= val_nxt;
      gate_oe_r <= oe_nxt;
      cmp_val_r <= cmp_val;
    end
  end

endmodule // ftg_gate_lib
`default_nettype wire

/* tb/ftg_gate_lib_chk.sv */
// Checker for the four-state gate array and compound gate.
// Assumes binding to ftg_gate_lib with its 3-cycle output latency.
`timescale 1ns/1ps
`default_nettype none
module ftg_gate_lib_chk #(parameter N_IN = 2, parameter N_GATE = 3) (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Watched ports
  input wire [2*N_IN*N_GATE-1:0] gate_in,
  input wire [2:0] gate_op,
  input wire tri_mode,
  input wire [1:0] tri_en,
  input wire [1:0] cmp_op,
  input wire [2*N_GATE-1:0] gate_val_r,
  input wire [N_GATE-1:0] gate_oe_r,
  input wire [1:0] cmp_val_r
);
  // ****
  // Settle counter
  // ****
  reg [2:0] up_r;
  wire ok = &up_r;
  wire [1:0] a0 = gate_in[1:0];
  wire [3:0] g0 = gate_in[3:0];
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) up_r <= 3'h0;
    else if (!ok) up_r <= up_r + 3'h1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ****
  // Assertions
  // ****
  std_oe_a: assert property (ok && !$past(tri_mode, 3) |-> &gate_oe_r)
    else $error("standard gate not driving");
  std_noz_a: assert property (ok && !$past(tri_mode, 3) |-> gate_val_r[1:0] != 2'h3)
    else $error("standard gate shows Z");
  tri_off_a: assert property (ok && $past(tri_mode, 3) && $past(tri_en, 3) == 2'h0 |->
    gate_oe_r == 0 && gate_val_r[1:0] == 2'h3) else $error("disabled gate drives");
  tri_on_a: assert property (ok && $past(tri_mode, 3) && $past(tri_en, 3) == 2'h1 |-> &gate_oe_r)
    else $error("enabled gate floats");
  and_zero_a: assert property (ok && !$past(tri_mode, 3) && $past(gate_op, 3) == 3'h2 &&
    $past(a0, 3) == 2'h0 |-> gate_val_r[1:0] == 2'h0) else $error("and with 0 not 0");
  or_one_a: assert property (ok && !$past(tri_mode, 3) && $past(gate_op, 3) == 3'h4 &&
    $past(a0, 3) == 2'h1 |-> gate_val_r[1:0] == 2'h1) else $error("or with 1 not 1");
  xor_unk_a: assert property (ok && !$past(tri_mode, 3) && $past(gate_op, 3) == 3'h6 &&
    $past(a0, 3) >= 2'h2 |-> gate_val_r[1:0] == 2'h2) else $error("xor with unknown not X");
  cmp_one_a: assert property (ok && $past(cmp_op, 3) == 2'h0 && $past(g0, 3) == 4'h5 |->
    cmp_val_r == 2'h1) else $error("and_or compound not 1");
  cover property (ok && gate_oe_r == 0);
  cover property (ok && gate_val_r[1:0] == 2'h2);
  cover property (ok && cmp_val_r == 2'h1);
endmodule // ftg_gate_lib_chk
bind ftg_gate_lib ftg_gate_lib_chk #(.N_IN(N_IN), .N_GATE(N_GATE)) u_chk(.clk(clk), .rst_b(rst_b),
  .gate_in(gate_in), .gate_op(gate_op), .tri_mode(tri_mode), .tri_en(tri_en), .cmp_op(cmp_op),
  .gate_val_r(gate_val_r), .gate_oe_r(gate_oe_r), .cmp_val_r(cmp_val_r));
`default_nettype wire

/* tb/tb_top.sv */
// Self-checking bench for the four-state gate library.
// Assumes the 3-cycle latency and codes 0/1/X/Z as 0/1/2/3.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_errors++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module tb_top;
  // ****
  // Stimulus and model
  // ****
  logic clk = 0, rst_b = 0, tri_mode = 0;
  logic [11:0] gate_in = 0;
  logic [2:0] gate_op = 0;
  logic [1:0] tri_en = 0, cmp_op = 0;
  wire [5:0] val;
  wire [2:0] oe;
  wire [1:0] cv;
  int n_errors = 0, samples_checked = 0, cyc = 0;
  logic [31:0] s = 32'h596a;
  logic [10:0] q[$];
  ftg_gate_lib #(.N_IN(2), .N_GATE(3)) dut(.clk(clk), .rst_b(rst_b), .gate_in(gate_in), .gate_op(gate_op),
    .tri_mode(tri_mode), .tri_en(tri_en), .cmp_op(cmp_op), .gate_val_r(val), .gate_oe_r(oe), .cmp_val_r(cv));
  function automatic [31:0] nx(input [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic [1:0] rd(input int op, input [5:0] v, input int n);
    int z = 0, o = 0, u = 0, p = 0;
    logic [1:0] r;
    for (int i = 0; i < n; i++) begin
      if (v[2*i+1]) u++;
      else if (v[2*i]) begin o++; p ^= 1; end
      else z++;
    end
    case (op / 2)
      0: r = v[1] ? 2'h2 : v[1:0];
      1: r = z ? 2'h0 : u ? 2'h2 : 2'h1;
      2: r = o ? 2'h1 : u ? 2'h2 : 2'h0;
      default: r = u ? 2'h2 : 2'(p);
    endcase
    return (op % 2 && r < 2) ? r ^ 2'h1 : r;
  endfunction
  function automatic [10:0] model();
    logic [5:0] v, f;
    logic [2:0] e;
    int sec[4] = '{4, 2, 5, 3};
    for (int g = 0; g < 3; g++) begin
      f[2*g+:2] = rd(cmp_op[0] ? 4 : 2, {2'h0, gate_in[4*g+:4]}, 2);
      v[2*g+:2] = rd(gate_op, {2'h0, gate_in[4*g+:4]}, 2);
      e[g] = !(tri_mode && tri_en == 2'h0);
      if (tri_mode && tri_en != 2'h1) v[2*g+:2] = e[g] ? 2'h2 : 2'h3;
    end
    return {v, e, rd(sec[cmp_op], f, 3)};
  endfunction
  task automatic print_verdict();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ****
  // Clock, timeout and sequence
  // ****
  initial begin
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_errors++;
      print_verdict();
    end
  end
  initial begin
    logic [10:0] e;
    repeat (2) @(negedge clk);
    rst_b = 1;
    repeat (6) @(negedge clk);
    for (int i = 0; i < 1600; i++) begin
      if (q.size() == 3) begin
        e = q.pop_front();
        `CHK(val, e[10:5])
        `CHK(oe, e[4:2])
        `CHK(cv, e[1:0])
      end
      s = nx(s);
      {tri_en, cmp_op, gate_in} = s[15:0];
      gate_op = i[2:0];
      tri_mode = s[16] & s[17];
      q.push_back(model());
      @(negedge clk);
    end
    print_verdict();
  end
endmodule // tb_top
`default_nettype wire
